//--- logic/pos_map_pkg.sv
package pos_map_pkg;

  // scaling factor range and default
  localparam logic [13:0] FACTOR_MIN = 14'h0001;
  localparam logic [13:0] FACTOR_MAX = 14'h2710;
  localparam logic [13:0] FACTOR_DEF = 14'h0190;

  // native encoder resolution and rotation counts
  localparam int STEPS_PER_REV = 32'h0000_0190;
  localparam int ENC_ROT       = 32'h0000_0100;
  localparam int END_ROT       = 32'h0000_00FD;
  localparam int MARGIN_ROT    = 32'h0000_0003;
  localparam int USABLE_ROT    = ENC_ROT - 2 * MARGIN_ROT;

  // native step counts derived from rotations
  localparam logic [16:0]        ENC_SPAN      = 17'(ENC_ROT * STEPS_PER_REV);
  localparam logic signed [63:0] MARGIN_NATIVE = 64'(MARGIN_ROT * STEPS_PER_REV);
  localparam logic signed [63:0] SPAN_NATIVE   = 64'(END_ROT * STEPS_PER_REV);

  // factory default state of the range parameters
  localparam logic signed [31:0] UME_DEF  = 32'(ENC_ROT * STEPS_PER_REV);
  localparam logic signed [31:0] LO_DEF   = 32'((ENC_ROT - END_ROT) * STEPS_PER_REV);
  localparam logic signed [31:0] HI_DEF   = 32'((ENC_ROT - MARGIN_ROT) * STEPS_PER_REV);
  localparam logic signed [31:0] REF_DEF  = 32'h0000_0000;
  localparam logic signed [31:0] DRAG_DEF = 32'h0000_0000;

  // rescale walks five stored values, index 4 is the last
  localparam logic [2:0] RESCALE_LAST = 3'h4;

  typedef enum logic [2:0] {
    SEL_NUM  = 3'h0,
    SEL_DEN  = 3'h1,
    SEL_REF  = 3'h2,
    SEL_ACT  = 3'h3,
    SEL_UME  = 3'h4,
    SEL_LO   = 3'h5,
    SEL_HI   = 3'h6,
    SEL_DRAG = 3'h7
  } par_sel_t;

  typedef enum logic [1:0] {
    ST_MARGIN  = 2'h0,
    ST_SPAN    = 2'h1,
    ST_PHYS    = 2'h2,
    ST_RESCALE = 2'h3
  } seq_t;

  typedef struct packed {
    logic                valid;
    par_sel_t            sel;
    logic signed [31:0]  data;
  } par_wr_t;

  typedef struct packed {
    logic signed [31:0]  ref_val;
    logic signed [31:0]  ump_end;
    logic signed [31:0]  lo_lim;
    logic signed [31:0]  hi_lim;
  } range_t;

endpackage

//--- logic/round_div.sv
module round_div (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire logic signed [63:0] dividend,
  input  wire logic [31:0]        divisor,
  output logic                    done,
  output logic signed [63:0]      quotient
);

  typedef struct packed {
    logic               busy;
    logic [6:0]         cnt;
    logic               neg;
    logic [63:0]        q;
    logic [31:0]        rem;
    logic               done;
    logic signed [63:0] quot;
  } div_st_t;

  div_st_t s;
  div_st_t next_s;

  // restoring division of the magnitude, half the divisor added first so the result rounds to nearest
  always_comb begin
    logic [32:0] sh;
    logic [33:0] trial;
    logic [63:0] qn;
    logic [63:0] mag;
    next_s = s;
    next_s.done = 1'b0;
    sh = {s.rem, s.q[63]};
    trial = {1'b0, sh} - {2'h0, divisor};
    qn = {s.q[62:0], ~trial[33]};
    mag = dividend[63] ? 64'(-dividend) : 64'(dividend);
    if (start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.cnt = 7'h40;
      next_s.neg = dividend[63];
      next_s.q = mag + {33'h0, divisor[31:1]};
      next_s.rem = 32'h0000_0000;
    end else if (s.busy) begin
      next_s.rem = trial[33] ? sh[31:0] : trial[31:0];
      next_s.q = qn;
      next_s.cnt = s.cnt - 7'h01;
      if (s.cnt == 7'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.quot = s.neg ? -$signed(qn) : $signed(qn);
      end
    end
    if (!rst_n) begin
      next_s = '0;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  assign done = s.done;
  assign quotient = s.quot;

endmodule

//--- logic/position_range_mapping.sv
// Behaviour
// - reject upper end leaving actual more than one step outside range
// - scaled bounds round to nearest integer
// - accepted upper end sets both limits
// - 256 rotations, 3 margin each end
// - steps per rev: 400 times den/num
// - both factors default to 400
// - factors accept only 1 to 10000
// - running: drag bit when difference exceeds threshold
// - zero threshold disables drag monitoring
// - limits may only be narrowed afterwards
// - offset written directly or from actual
// - direction setting mirrors position counting
// - targets inside safety margins refused
// - factory default upper end 102400, centred
// - factor change rescales stored position values
module position_range_mapping (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [16:0]          enc_count,
  input  wire logic                 dir_reverse,
  input  wire pos_map_pkg::par_wr_t par_wr,
  input  wire logic                 run_req,
  input  wire logic signed [31:0]   run_target,
  input  wire logic                 run_active,
  input  wire logic signed [31:0]   cmd_target,
  output logic signed [31:0]        actual_pos,
  output pos_map_pkg::range_t       range,
  output logic [13:0]               num_factor,
  output logic [13:0]               den_factor,
  output logic signed [31:0]        drag_threshold,
  output logic                      busy,
  output logic                      wr_ack,
  output logic                      wr_reject,
  output logic                      run_accept,
  output logic                      target_error,
  output logic                      drag_error
);

  typedef struct packed {
    pos_map_pkg::seq_t  st;
    logic               wait_div;
    logic               flush;
    logic [2:0]         rs_idx;
    logic [13:0]        num;
    logic [13:0]        den;
    logic [13:0]        old_num;
    logic [13:0]        old_den;
    logic signed [31:0] phys;
    logic signed [31:0] act;
    logic signed [31:0] ref_val;
    logic signed [31:0] ump_end;
    logic signed [31:0] lo_lim;
    logic signed [31:0] hi_lim;
    logic signed [31:0] drag_thr;
    logic signed [31:0] margin;
    logic signed [31:0] span;
    logic               dv_start;
    logic signed [63:0] dv_num;
    logic [31:0]        dv_den;
    logic               busy;
    logic               wr_ack;
    logic               wr_reject;
    logic               run_ok;
    logic               tgt_err;
    logic               drag_err;
  } map_st_t;

  map_st_t            s;
  map_st_t            next_s;
  logic               dv_done;
  logic signed [63:0] dv_q;

  round_div u_div (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .start    (s.dv_start),
    .dividend (s.dv_num),
    .divisor  (s.dv_den),
    .done     (dv_done),
    .quotient (dv_q)
  );

  // stored value walked by the rescale step
  function automatic logic signed [31:0] pick(input map_st_t v, input logic [2:0] i);
    case (i)
      3'h0:    pick = v.ref_val;
      3'h1:    pick = v.ump_end;
      3'h2:    pick = v.lo_lim;
      3'h3:    pick = v.hi_lim;
      default: pick = v.drag_thr;
    endcase
  endfunction

  // sequencer, parameter writes, run checks and drag monitor
  always_comb begin
    logic [16:0]        native;
    logic signed [63:0] den64;
    logic signed [31:0] res;
    logic signed [32:0] lo_new;
    logic signed [32:0] hi_new;
    logic signed [32:0] diff;
    logic signed [32:0] mag;
    next_s = s;
    next_s.dv_start = 1'b0;
    next_s.wr_ack = 1'b0;
    next_s.wr_reject = 1'b0;
    next_s.run_ok = 1'b0;
    native = dir_reverse ? pos_map_pkg::ENC_SPAN - enc_count : enc_count;
    den64 = {50'h0, s.den};
    res = $signed(dv_q[31:0]);
    lo_new = 33'(par_wr.data) - 33'(s.span);
    hi_new = 33'(par_wr.data) - 33'(s.margin);
    diff = 33'(cmd_target) - 33'(s.act);
    mag = diff[32] ? -diff : diff;

    // issue the next division of the current step
    if (!s.wait_div) begin
      next_s.wait_div = 1'b1;
      next_s.dv_start = 1'b1;
      next_s.dv_den = {18'h0, s.num};
      unique case (s.st)
        pos_map_pkg::ST_MARGIN:  next_s.dv_num = pos_map_pkg::MARGIN_NATIVE * den64;
        pos_map_pkg::ST_SPAN:    next_s.dv_num = pos_map_pkg::SPAN_NATIVE * den64;
        pos_map_pkg::ST_PHYS:    next_s.dv_num = 64'(native) * den64;
        pos_map_pkg::ST_RESCALE: begin
          next_s.dv_num = 64'(pick(s, s.rs_idx)) * den64 * $signed({50'h0, s.old_num});
          next_s.dv_den = 32'(s.num * s.old_den);
        end
      endcase
    end else if (dv_done) begin
      next_s.wait_div = 1'b0;
      if (s.flush) begin
        next_s.flush = 1'b0;
      end else begin
        unique case (s.st)
          pos_map_pkg::ST_MARGIN: begin
            next_s.margin = res;
            next_s.st = pos_map_pkg::ST_SPAN;
          end
          pos_map_pkg::ST_SPAN: begin
            next_s.span = res;
            next_s.st = pos_map_pkg::ST_PHYS;
          end
          pos_map_pkg::ST_PHYS: begin
            next_s.phys = res;
            next_s.act = res + s.ref_val;
          end
          pos_map_pkg::ST_RESCALE: begin
            case (s.rs_idx)
              3'h0:    next_s.ref_val = res;
              3'h1:    next_s.ump_end = res;
              3'h2:    next_s.lo_lim = res;
              3'h3:    next_s.hi_lim = res;
              default: next_s.drag_thr = res;
            endcase
            next_s.rs_idx = s.rs_idx + 3'h1;
            if (s.rs_idx == pos_map_pkg::RESCALE_LAST) begin
              next_s.st = pos_map_pkg::ST_MARGIN;
            end
          end
        endcase
      end
    end

    // parameter writes; refused while a recalculation runs
    if (par_wr.valid) begin
      next_s.wr_reject = 1'b1;
      if (s.st == pos_map_pkg::ST_PHYS) begin
        unique case (par_wr.sel)
          pos_map_pkg::SEL_NUM, pos_map_pkg::SEL_DEN: begin
            if (par_wr.data >= 32'(pos_map_pkg::FACTOR_MIN) && par_wr.data <= 32'(pos_map_pkg::FACTOR_MAX)) begin
              next_s.wr_reject = 1'b0;
              next_s.wr_ack = 1'b1;
              next_s.old_num = s.num;
              next_s.old_den = s.den;
              if (par_wr.sel == pos_map_pkg::SEL_NUM) begin
                next_s.num = par_wr.data[13:0];
              end else begin
                next_s.den = par_wr.data[13:0];
              end
              next_s.st = pos_map_pkg::ST_RESCALE;
              next_s.rs_idx = 3'h0;
              next_s.dv_start = 1'b0; // a launch this cycle would still use the old factors
              next_s.flush = s.wait_div && !dv_done;
              next_s.wait_div = s.wait_div && !dv_done;
            end
          end
          pos_map_pkg::SEL_REF, pos_map_pkg::SEL_ACT: begin
            next_s.wr_reject = 1'b0;
            next_s.wr_ack = 1'b1;
            next_s.ref_val = (par_wr.sel == pos_map_pkg::SEL_REF) ? par_wr.data : par_wr.data - s.phys;
            next_s.act = s.phys + next_s.ref_val;
          end
          pos_map_pkg::SEL_UME: begin
            if (lo_new - 33'sh1 <= 33'(s.act) && 33'(s.act) <= hi_new + 33'sh1) begin
              next_s.wr_reject = 1'b0;
              next_s.wr_ack = 1'b1;
              next_s.ump_end = par_wr.data;
              next_s.lo_lim = lo_new[31:0];
              next_s.hi_lim = hi_new[31:0];
            end
          end
          pos_map_pkg::SEL_LO: begin
            if (par_wr.data >= s.ump_end - s.span && par_wr.data <= s.hi_lim) begin
              next_s.wr_reject = 1'b0;
              next_s.wr_ack = 1'b1;
              next_s.lo_lim = par_wr.data;
            end
          end
          pos_map_pkg::SEL_HI: begin
            if (par_wr.data <= s.ump_end - s.margin && par_wr.data >= s.lo_lim) begin
              next_s.wr_reject = 1'b0;
              next_s.wr_ack = 1'b1;
              next_s.hi_lim = par_wr.data;
            end
          end
          pos_map_pkg::SEL_DRAG: begin
            if (!par_wr.data[31]) begin
              next_s.wr_reject = 1'b0;
              next_s.wr_ack = 1'b1;
              next_s.drag_thr = par_wr.data;
            end
          end
        endcase
      end
    end

    // run request: target must keep clear of the safety margins
    if (run_req) begin
      next_s.drag_err = 1'b0;
      if (run_target < s.ump_end - s.span || run_target > s.ump_end - s.margin) begin
        next_s.tgt_err = 1'b1;
      end else begin
        next_s.tgt_err = 1'b0;
        next_s.run_ok = 1'b1;
      end
    end

    // drag monitor; a detection wins over the clear at run start
    if (run_active && s.drag_thr != 32'sh0 && mag > 33'(s.drag_thr)) begin
      next_s.drag_err = 1'b1;
    end

    next_s.busy = next_s.st != pos_map_pkg::ST_PHYS;

    // factory default state
    if (!rst_n) begin
      next_s = '0;
      next_s.st = pos_map_pkg::ST_MARGIN;
      next_s.busy = 1'b1;
      next_s.num = pos_map_pkg::FACTOR_DEF;
      next_s.den = pos_map_pkg::FACTOR_DEF;
      next_s.old_num = pos_map_pkg::FACTOR_DEF;
      next_s.old_den = pos_map_pkg::FACTOR_DEF;
      next_s.ref_val = pos_map_pkg::REF_DEF;
      next_s.ump_end = pos_map_pkg::UME_DEF;
      next_s.lo_lim = pos_map_pkg::LO_DEF;
      next_s.hi_lim = pos_map_pkg::HI_DEF;
      next_s.drag_thr = pos_map_pkg::DRAG_DEF;
      next_s.margin = 32'(pos_map_pkg::MARGIN_NATIVE);
      next_s.span = 32'(pos_map_pkg::SPAN_NATIVE);
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  // outputs straight from the state register
  assign actual_pos     = s.act;
  assign range          = '{ref_val: s.ref_val, ump_end: s.ump_end, lo_lim: s.lo_lim, hi_lim: s.hi_lim};
  assign num_factor     = s.num;
  assign den_factor     = s.den;
  assign drag_threshold = s.drag_thr;
  assign busy           = s.busy;
  assign wr_ack         = s.wr_ack;
  assign wr_reject      = s.wr_reject;
  assign run_accept     = s.run_ok;
  assign target_error   = s.tgt_err;
  assign drag_error     = s.drag_err;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  factor_range_a: assert property (
    par_wr.valid && par_wr.sel == pos_map_pkg::SEL_DEN && par_wr.data > 32'sd10000 |=> wr_reject && !wr_ack)
    else $error("out of range factor not rejected");
  ume_window_a: assert property (
    wr_ack && $past(par_wr.sel) == pos_map_pkg::SEL_UME |-> $past(s.act) >= range.lo_lim - 32'sd1
    && $past(s.act) <= range.hi_lim + 32'sd1)
    else $error("accepted upper end leaves actual outside range");
  limit_recalc_a: assert property (
    wr_ack && $past(par_wr.sel) == pos_map_pkg::SEL_UME |-> range.lo_lim == range.ump_end - s.span
    && range.hi_lim == range.ump_end - s.margin)
    else $error("limits not derived from upper end");
  drag_set_a: assert property (
    run_active && !run_req && s.drag_thr > 32'sh0000_0000
    && (cmd_target - s.act > s.drag_thr || s.act - cmd_target > s.drag_thr) |=> drag_error)
    else $error("drag error not raised");
  drag_off_a: assert property (
    run_req && s.drag_thr == 32'sd0 |=> !drag_error)
    else $error("drag error raised while disabled");
  target_refuse_a: assert property (
    run_req && run_target > range.ump_end - s.margin |=> target_error && !run_accept)
    else $error("target in margin accepted");
  default_state_a: assert property (
    $rose(rst_n) |-> range.ump_end == 32'sh0001_9000 && range.lo_lim == 32'sh0000_04B0 && num_factor == 14'h0190)
    else $error("factory default wrong");
  factor_rescale_a: assert property (
    wr_ack && $past(par_wr.sel) == pos_map_pkg::SEL_NUM |-> busy ##1 busy[*8])
    else $error("factor change did not rescale");
  ref_from_act_a: assert property (
    par_wr.valid && par_wr.sel == pos_map_pkg::SEL_ACT && !busy |=> range.ref_val == $past(par_wr.data) - $past(s.phys))
    else $error("offset from actual wrong");
  narrow_only_a: assert property (
    wr_ack && $past(par_wr.sel) == pos_map_pkg::SEL_LO |-> range.lo_lim >= range.ump_end - s.span)
    else $error("lower limit widened");

endmodule

//--- testbench/fieldbus_master.sv
module fieldbus_master (
  input  wire logic            sys_clk,
  input  wire logic            wr_ack,
  input  wire logic            wr_reject,
  output pos_map_pkg::par_wr_t par_wr
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus starts idle
  initial par_wr = '0;

  // one parameter write; the answer is read just after the edge that takes it
  task automatic write_par(input pos_map_pkg::par_sel_t sel, input logic signed [31:0] data,
                           input int gap, output logic ack, output logic rej);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    par_wr <= '{valid: 1'b1, sel: sel, data: data};
    @(posedge sys_clk);
    // released bus shows the inverse word so a stale copy cannot pass
    par_wr <= '{valid: 1'b0, sel: pos_map_pkg::par_sel_t'(~sel), data: ~data};
    #1;
    ack = wr_ack;
    rej = wr_reject;
  endtask
endmodule

//--- testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic signed [31:0] FULL   = 32'sh0001_9000;
  localparam logic signed [31:0] MARGIN = 32'sh0000_04B0;
  localparam logic signed [31:0] SPAN   = 32'sh0001_8B50;

  logic                   sys_clk;
  logic                   rst_n;
  logic [16:0]            enc_count;
  logic                   dir_reverse;
  pos_map_pkg::par_wr_t   par_wr;
  logic                   run_req;
  logic signed [31:0]     run_target;
  logic                   run_active;
  logic signed [31:0]     cmd_target;
  logic signed [31:0]     actual_pos;
  pos_map_pkg::range_t    range;
  logic [13:0]            num_factor;
  logic [13:0]            den_factor;
  logic signed [31:0]     drag_threshold;
  logic                   busy;
  logic                   wr_ack;
  logic                   wr_reject;
  logic                   run_accept;
  logic                   target_error;
  logic                   drag_error;
  int                     n_fail;
  int                     checks;
  int                     i;
  logic [31:0]            lfsr;
  logic [13:0]            num;
  logic [13:0]            den;
  logic signed [31:0]     nat;
  logic signed [31:0]     ref_exp;
  logic signed [31:0]     act_exp;
  logic signed [31:0]     ump;
  logic signed [31:0]     d;
  logic                   ack;
  logic                   rej;
  pos_map_pkg::par_sel_t  fsel [6] = '{pos_map_pkg::SEL_NUM, pos_map_pkg::SEL_DEN, pos_map_pkg::SEL_DEN,
                                       pos_map_pkg::SEL_NUM, pos_map_pkg::SEL_NUM, pos_map_pkg::SEL_DEN};
  logic [13:0]            fval [6] = '{14'h0000, 14'h2711, 14'h2710, 14'h0001, 14'h0190, 14'h0190};
  logic                   fok  [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic signed [31:0]     dv   [4] = '{32'sh0000_04AE, 32'sh0000_04AF, 32'sh0001_8B51, 32'sh0001_8B52};
  logic                   dok  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  position_range_mapping DUT (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .enc_count      (enc_count),
    .dir_reverse    (dir_reverse),
    .par_wr         (par_wr),
    .run_req        (run_req),
    .run_target     (run_target),
    .run_active     (run_active),
    .cmd_target     (cmd_target),
    .actual_pos     (actual_pos),
    .range          (range),
    .num_factor     (num_factor),
    .den_factor     (den_factor),
    .drag_threshold (drag_threshold),
    .busy           (busy),
    .wr_ack         (wr_ack),
    .wr_reject      (wr_reject),
    .run_accept     (run_accept),
    .target_error   (target_error),
    .drag_error     (drag_error)
  );

  fieldbus_master master (
    .sys_clk   (sys_clk),
    .wr_ack    (wr_ack),
    .wr_reject (wr_reject),
    .par_wr    (par_wr)
  );

  // 50 ns clock
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // pseudo-random source, seeded at 84
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // native position as counted in the selected direction
  function automatic logic signed [31:0] native(input logic [16:0] e, input logic rev);
    return rev ? FULL - 32'(e) : 32'(e);
  endfunction

  // signed division rounded to nearest, halves away from zero
  function automatic logic signed [31:0] rdiv(input logic signed [63:0] a, input logic signed [63:0] b);
    return 32'(a < 0 ? -((-a + b / 2) / b) : (a + b / 2) / b);
  endfunction

  task automatic chk(input logic signed [63:0] seen, input logic signed [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) tick();
    if (busy !== 1'b0) begin
      chk(busy, 0, "busy stuck");
      give_verdict();
    end
  endtask

  task automatic wr(input pos_map_pkg::par_sel_t sel, input logic signed [31:0] data, input logic ok);
    master.write_par(sel, data, 0, ack, rej);
    chk({ack, rej}, ok ? 2'b10 : 2'b01, "write answer");
  endtask

  task automatic run(input logic signed [31:0] t, input logic ok);
    @(posedge sys_clk);
    run_req    <= 1'b1;
    run_target <= t;
    @(posedge sys_clk);
    run_req <= 1'b0;
    #1;
    chk({run_accept, target_error}, ok ? 2'b10 : 2'b01, "run answer");
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    enc_count = 17'h04B00;
    dir_reverse = 1'b0;
    run_req = 1'b0;
    run_target = '0;
    run_active = 1'b0;
    cmd_target = '0;
    n_fail = 0;
    checks = 0;
    lfsr = 32'h0000_0054;
    ref_exp = '0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick();
    chk(num_factor, 14'h0190, "num default");
    chk(den_factor, 14'h0190, "den default");
    chk(range.ump_end, FULL, "upper end default");
    chk(range.lo_lim, MARGIN, "lower default");
    chk(range.hi_lim, SPAN, "upper default");
    chk(drag_threshold, 0, "drag default");
    $display("test reset done");
    // direction before factors
    @(posedge sys_clk);
    dir_reverse <= 1'b1;
    wait_idle();
    wr(pos_map_pkg::SEL_DEN, 32'sh0000_0320, 1'b1);
    wr(pos_map_pkg::SEL_DRAG, 32'sh0000_0005, 1'b0);
    wait_idle();
    chk(range.ump_end, 2 * FULL, "rescaled upper end");
    chk(range.hi_lim, 2 * SPAN, "rescaled upper limit");
    repeat (200) tick();
    chk(actual_pos, 2 * (FULL - 32'sh0000_4B00), "scaled reversed position");
    num = 14'h0190;
    den = 14'h0320;
    // factor limits; each accepted value rescales the range
    for (i = 0; i < 6; i++) begin
      wr(fsel[i], 32'(fval[i]), fok[i]);
      if (fok[i] && fsel[i] == pos_map_pkg::SEL_NUM) num = fval[i];
      if (fok[i] && fsel[i] == pos_map_pkg::SEL_DEN) den = fval[i];
      wait_idle();
      chk({den_factor, num_factor}, {den, num}, "factors");
      chk(range.ump_end, 64'(FULL) * den / num, "upper end rescale");
      chk(range.hi_lim, 64'(SPAN) * den / num, "upper limit rescale");
    end
    $display("test factors done");
    // random positions, referencing, then upper ends
    for (i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge sys_clk);
      enc_count <= 17'(lfsr % 32'h0001_9001);
      dir_reverse <= lfsr[20];
      nat = native(17'(lfsr % 32'h0001_9001), lfsr[20]);
      repeat (200) tick();
      chk(actual_pos, nat + ref_exp, "actual position");
      lfsr = lfsr_next(lfsr);
      act_exp = 32'(lfsr % 32'h0003_0D40);
      wr(pos_map_pkg::SEL_ACT, act_exp, 1'b1);
      ref_exp = act_exp - nat;
      chk(range.ref_val, ref_exp, "offset from actual");
      repeat (200) tick();
      chk(actual_pos, act_exp, "referenced position");
      for (int j = 0; j < 4; j++) wr(pos_map_pkg::SEL_UME, act_exp + dv[j], dok[j]);
      lfsr = lfsr_next(lfsr);
      d = MARGIN + 32'(lfsr % 32'h0001_86A1);
      ump = act_exp + d;
      wr(pos_map_pkg::SEL_UME, ump, 1'b1);
      chk(range.ump_end, ump, "upper end");
      chk(range.lo_lim, ump - SPAN, "lower limit");
      chk(range.hi_lim, ump - MARGIN, "upper limit");
    end
    $display("test upper end done");
    // run targets against the margins
    run(ump - SPAN - 1, 1'b0);
    run(ump - SPAN, 1'b1);
    run(ump - MARGIN + 1, 1'b0);
    repeat (3) tick();
    chk(target_error, 1'b1, "target error held");
    run(ump - MARGIN, 1'b1);
    $display("test runs done");
    // narrowing the range
    wr(pos_map_pkg::SEL_LO, ump - SPAN + 10, 1'b1);
    chk(range.lo_lim, ump - SPAN + 10, "narrowed lower");
    wr(pos_map_pkg::SEL_LO, ump - SPAN - 1, 1'b0);
    wr(pos_map_pkg::SEL_HI, ump - MARGIN - 10, 1'b1);
    chk(range.hi_lim, ump - MARGIN - 10, "narrowed upper");
    wr(pos_map_pkg::SEL_HI, ump - MARGIN + 1, 1'b0);
    wr(pos_map_pkg::SEL_HI, ump - SPAN + 9, 1'b0);
    $display("test narrowing done");
    // drag monitoring while running
    wr(pos_map_pkg::SEL_DRAG, 32'sh0000_002C, 1'b1);
    chk(drag_threshold, 32'sh0000_002C, "drag threshold");
    wr(pos_map_pkg::SEL_DRAG, -32'sh0000_0001, 1'b0);
    @(posedge sys_clk);
    run_active <= 1'b1;
    cmd_target <= act_exp + 32'sh0000_002C;
    repeat (3) tick();
    chk(drag_error, 1'b0, "drag at threshold");
    @(posedge sys_clk);
    cmd_target <= act_exp - 32'sh0000_002D;
    repeat (2) tick();
    chk(drag_error, 1'b1, "drag above threshold");
    @(posedge sys_clk);
    cmd_target <= act_exp;
    run(ump - SPAN, 1'b1);
    chk(drag_error, 1'b0, "drag cleared by run");
    wr(pos_map_pkg::SEL_DRAG, 32'sh0000_0000, 1'b1);
    @(posedge sys_clk);
    cmd_target <= act_exp + 32'sh0001_86A0;
    repeat (3) tick();
    chk(drag_error, 1'b0, "drag monitoring off");
    @(posedge sys_clk);
    run_active <= 1'b0;
    $display("test drag done");
    // odd numerator: scaled position and upper end bounds round to nearest
    wr(pos_map_pkg::SEL_NUM, 32'sh0000_0007, 1'b1);
    wait_idle();
    repeat (200) tick();
    act_exp = rdiv(64'(nat) * 400, 7) + rdiv(64'(ref_exp) * 400, 7);
    chk(actual_pos, act_exp, "rounded position");
    d = rdiv(64'(MARGIN) * 400, 7);
    wr(pos_map_pkg::SEL_UME, act_exp + d - 2, 1'b0);
    ump = act_exp + d - 1;
    wr(pos_map_pkg::SEL_UME, ump, 1'b1);
    chk(range.hi_lim, ump - d, "rounded upper limit");
    chk(range.lo_lim, ump - rdiv(64'(SPAN) * 400, 7), "rounded lower limit");
    // referencing value written directly
    wr(pos_map_pkg::SEL_REF, 32'sh0000_0064, 1'b1);
    chk(range.ref_val, 32'sh0000_0064, "direct offset");
    chk(actual_pos, rdiv(64'(nat) * 400, 7) + 32'sh0000_0064, "offset applied");
    $display("test rounding done");
    give_verdict();
  end
endmodule
